// File: common/fsc_defines.vh
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH

// Clock and timing
`define FSC_CLK_MHZ      200
`define FSC_STEP_NS      1000000
`define FSC_STEP_CYC     ((`FSC_STEP_NS * `FSC_CLK_MHZ) / 1000)
`define FSC_TPULSE_NS    2000
`define FSC_TPULSE_CYC   ((`FSC_TPULSE_NS * `FSC_CLK_MHZ) / 1000)

// Register byte addresses
`define FSC_A_CTRL       8'h00
`define FSC_A_CMD        8'h04
`define FSC_A_STAT       8'h08
`define FSC_A_TIME       8'h0C
`define FSC_A_START_LO   8'h10
`define FSC_A_START_HI   8'h14
`define FSC_A_STOP_LO    8'h18
`define FSC_A_STOP_HI    8'h1C
`define FSC_A_CENT_LO    8'h20
`define FSC_A_CENT_HI    8'h24
`define FSC_A_SPAN_LO    8'h28
`define FSC_A_SPAN_HI    8'h2C
`define FSC_A_MARK_LO    8'h30
`define FSC_A_MARK_HI    8'h34
`define FSC_A_RATIO      8'h38
`define FSC_A_FREQ_LO    8'h3C
`define FSC_A_FREQ_HI    8'h40

// Control field positions
`define FSC_C_EN         0
`define FSC_C_LOG        1
`define FSC_C_SRC_LO     2
`define FSC_C_SRC_HI     3
`define FSC_C_TIN_NEG    4
`define FSC_C_TOUT_EN    5
`define FSC_C_TOUT_NEG   6
`define FSC_C_MARK_EN    7
`define FSC_C_SYNC_EN    8
`define FSC_C_FUNC_LO    9
`define FSC_C_FUNC_HI    10

// Command bits
`define FSC_K_TRG        0
`define FSC_K_COMBINED_WAVEFORM_A      1
`define FSC_K_OPC        2

// Status bits
`define FSC_S_OPC        0
`define FSC_S_CONFLICT   1

// Encodings
`define FSC_SRC_IMM      2'h0
`define FSC_SRC_EXT      2'h1
`define FSC_SRC_BUS      2'h2
`define FSC_FN_RAMP      2'h2
`define FSC_FN_ARB       2'h3

// Frequencies in micro-hertz
`define FSC_F_MIN        48'h0000_0000_0001
`define FSC_F_MAX        48'h48C2_7395_0000
`define FSC_F_MAX_ARB    48'h16BC_C41E_9000
`define FSC_F_MAX_RAMP   48'h00E8_D4A5_1000
`define FSC_F_START_RST  48'h0000_05F5_E100
`define FSC_F_STOP_RST   48'h0000_3B9A_CA00
`define FSC_F_MARK_RST   48'h0000_1DCD_6500

// Sweep time in ms and log ratio
`define FSC_TIME_RST     19'h003E8
`define FSC_RATIO_RST    32'h0100_0000

`endif

// File: logic/fsc_sweep.v
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/10ps
`include "fsc_defines.vh"

module fsc_sweep #(
	parameter STEP_CYC = `FSC_STEP_CYC
) (
	// Clock and reset
	input  wire        I_CORE_CLK,
	input  wire        I_RST,
	// Register port
	input  wire [7:0]  I_ADDR,
	input  wire [31:0] I_WDATA,
	input  wire        I_WR,
	input  wire        I_RD,
	output reg  [31:0] O_RDATA,
	// Pins and neighbours
	input  wire        I_TRIG_IN,
	input  wire        I_CARRIER_SYNC,
	output reg         O_TRIG_OUT,
	output reg         O_TRIG_OUT_OE_N,
	output reg         O_SYNC,
	output reg         O_TRIG_LAMP,
	output reg         O_MODES_OFF,
	output reg  [47:0] O_FREQ
);

	localparam ST_IDLE = 4'b0001;
	localparam ST_WAIT = 4'b0010;
	localparam ST_DIV  = 4'b0100;
	localparam ST_RUN  = 4'b1000;
	localparam [31:0] STEP_LAST = STEP_CYC - 1;
	localparam [31:0] STEP_HALF = STEP_CYC / 2;
	localparam [31:0] TP_FULL   = `FSC_TPULSE_CYC - 1;
	// Pulse count fits 16 bits for any sane clock
	localparam [15:0] TP_LAST   = TP_FULL[15:0];

	// Per-function frequency ceiling
	function [47:0] fmax_of;
		input [1:0] fn;
		begin
			case (fn)
				`FSC_FN_RAMP: fmax_of = `FSC_F_MAX_RAMP;
				`FSC_FN_ARB:  fmax_of = `FSC_F_MAX_ARB;
				default:      fmax_of = `FSC_F_MAX;
			endcase
		end
	endfunction

	// Clamp into 1 uHz .. ceiling
	function [47:0] clampf;
		input [47:0] v;
		input [47:0] hi;
		begin
			if (v < `FSC_F_MIN)
				clampf = `FSC_F_MIN;
			else if (v > hi)
				clampf = hi;
			else
				clampf = v;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers
	reg  [10:0] ctrl_q;
	reg  [18:0] time_q;
	reg  [47:0] start_q, stop_q, mark_q;
	reg  [31:0] ratio_q, stage_q;
	reg         opc_q, conflict_q, opc_req_q;
	reg  [3:0]  st_q;
	reg  [47:0] freq_q, inc_q, quo_q, dvd_q;
	reg  [19:0] rem_q;
	reg  [5:0]  bit_q;
	reg  [18:0] step_idx_q;
	reg  [31:0] step_cnt_q;
	reg  [15:0] tp_cnt_q;
	reg         mark_lvl_q;
	reg         tin_m_q, tin_s_q, tin_d_q;
	reg  [31:0] rd_mux;

	wire [1:0]  src    = ctrl_q[`FSC_C_SRC_HI:`FSC_C_SRC_LO];
	wire [47:0] fmax   = fmax_of(ctrl_q[`FSC_C_FUNC_HI:`FSC_C_FUNC_LO]);
	wire        up     = start_q < stop_q;
	wire [47:0] mag    = up ? stop_q - start_q : start_q - stop_q;
	wire [47:0] span   = stop_q - start_q;
	wire [48:0] sum    = {1'b0, start_q} + {1'b0, stop_q};
	wire [47:0] center = sum[48:1];
	wire [47:0] lo_f   = up ? start_q : stop_q;
	wire [47:0] hi_f   = up ? stop_q : start_q;
	wire [47:0] wide   = {I_WDATA[15:0], stage_q};
	wire [18:0] steps  = (time_q == 19'h0) ? 19'h1 : time_q;
	// Also ticks when a short step was outrun by the divide
	wire        tick   = step_cnt_q >= STEP_LAST;
	wire        last   = (step_idx_q + 19'h1) == steps;
	wire [79:0] prod   = freq_q * ratio_q;
	wire [47:0] ldelta = prod[79:32];
	wire [19:0] rsh    = {rem_q[18:0], dvd_q[47]};
	wire        wr_cmd = I_WR && I_ADDR == `FSC_A_CMD;
	wire        sw_en  = ctrl_q[`FSC_C_EN];

	// Center and span writes keep the other end inside the ceiling
	wire [47:0] half_m = mag >> 1;
	wire [47:0] cen_nx = clampf(wide, fmax - half_m);
	wire [47:0] spn_ab = wide[47] ? 48'h0 - wide : wide;
	wire [47:0] spn_lm = (fmax - center) << 1;
	wire [47:0] spn_c1 = (spn_ab > spn_lm) ? spn_lm : spn_ab;
	wire [47:0] spn_h  = ((spn_c1 > fmax) ? fmax : spn_c1) >> 1;
	// Log step clamps at stop, so a large ratio cannot overshoot
	wire [47:0] log_nx = up ?
		((ldelta > stop_q - freq_q) ? stop_q : freq_q + ldelta) :
		((ldelta > freq_q - stop_q) ? stop_q : freq_q - ldelta);
	// Square out in half steps: high for the first half of the sweep
	wire        sq_hi  = (st_q == ST_DIV || st_q == ST_RUN) &&
		({step_idx_q, step_cnt_q >= STEP_HALF} < {1'b0, steps});

	// Edge of chosen polarity on the synchronised trigger input
	wire ext_edge = ctrl_q[`FSC_C_TIN_NEG] ? (tin_d_q & ~tin_s_q)
		: (~tin_d_q & tin_s_q);
	wire bus_trg  = wr_cmd && I_WDATA[`FSC_K_TRG];
	wire start_ev = (src == `FSC_SRC_IMM) ||
		(src == `FSC_SRC_EXT && ext_edge) ||
		(src == `FSC_SRC_BUS && bus_trg);

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchroniser, then a delayed copy for edges
	always @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			tin_m_q <= 1'b0;
			tin_s_q <= 1'b0;
			tin_d_q <= 1'b0;
		end else begin
			tin_m_q <= I_TRIG_IN;
			tin_s_q <= tin_m_q;
			tin_d_q <= tin_s_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software-visible settings; center and span are views of start/stop
	always @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			ctrl_q      <= 11'h000;
			time_q      <= `FSC_TIME_RST;
			start_q     <= `FSC_F_START_RST;
			stop_q      <= `FSC_F_STOP_RST;
			mark_q      <= `FSC_F_MARK_RST;
			ratio_q     <= `FSC_RATIO_RST;
			stage_q     <= 32'h0000_0000;
			O_MODES_OFF <= 1'b0;
		end else begin
			O_MODES_OFF <= 1'b0;
			if (I_WR) begin
				case (I_ADDR)
					`FSC_A_CTRL: begin
						ctrl_q <= I_WDATA[10:0];
						// Enabling sweep drops burst/modulation
						O_MODES_OFF <= I_WDATA[`FSC_C_EN] & ~sw_en;
					end
					`FSC_A_CMD: begin
						if (I_WDATA[`FSC_K_COMBINED_WAVEFORM_A])
							ctrl_q[`FSC_C_SRC_HI:`FSC_C_SRC_LO] <=
								`FSC_SRC_IMM;
					end
					`FSC_A_TIME: begin
						// Sweep time in ms, 1 .. 500000
						if (I_WDATA[18:0] == 19'h0)
							time_q <= 19'h00001;
						else if (I_WDATA[31:19] != 13'h0 ||
							I_WDATA[18:0] > 19'h7A120)
							time_q <= 19'h7A120;
						else
							time_q <= I_WDATA[18:0];
					end
					`FSC_A_START_LO, `FSC_A_STOP_LO, `FSC_A_CENT_LO,
					`FSC_A_SPAN_LO, `FSC_A_MARK_LO:
						stage_q <= I_WDATA;
					`FSC_A_START_HI: start_q <= clampf(wide, fmax);
					`FSC_A_STOP_HI:  stop_q  <= clampf(wide, fmax);
					`FSC_A_MARK_HI:  mark_q  <= clampf(wide, fmax);
					`FSC_A_CENT_HI: begin
						// Center limited so stop stays under the ceiling
						start_q <= up ? cen_nx - half_m : cen_nx + half_m;
						stop_q  <= up ? cen_nx + half_m : cen_nx - half_m;
					end
					`FSC_A_SPAN_HI: begin
						// Magnitude limited by ceiling and center
						start_q <= wide[47] ? center + spn_h
							: center - spn_h;
						stop_q  <= wide[47] ? center - spn_h
							: center + spn_h;
					end
					`FSC_A_RATIO: ratio_q <= I_WDATA;
					default: ;
				endcase
			end else if (sw_en && mark_q < lo_f) begin
				mark_q <= lo_f;
			end else if (sw_en && mark_q > hi_f) begin
				mark_q <= hi_f;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky flags; an opc set wins over a write-one clear, conflict sets only in cycles without a write
	always @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			opc_q      <= 1'b0;
			conflict_q <= 1'b0;
			opc_req_q  <= 1'b0;
		end else begin
			if (wr_cmd && I_WDATA[`FSC_K_OPC])
				opc_req_q <= 1'b1;
			else if (st_q == ST_RUN && tick && last)
				opc_req_q <= 1'b0;
			if (st_q == ST_RUN && tick && last && opc_req_q)
				opc_q <= 1'b1;
			else if (I_WR && I_ADDR == `FSC_A_STAT && I_WDATA[`FSC_S_OPC])
				opc_q <= 1'b0;
			if (sw_en && !I_WR && (mark_q < lo_f || mark_q > hi_f))
				conflict_q <= 1'b1;
			else if (I_WR && I_ADDR == `FSC_A_STAT &&
				I_WDATA[`FSC_S_CONFLICT])
				conflict_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sweep engine: wait for trigger, derive increment, step
	always @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			st_q       <= ST_IDLE;
			freq_q     <= `FSC_F_START_RST;
			inc_q      <= 48'h0;
			quo_q      <= 48'h0;
			dvd_q      <= 48'h0;
			rem_q      <= 20'h0;
			bit_q      <= 6'h0;
			step_idx_q <= 19'h0;
			step_cnt_q <= 32'h0;
			mark_lvl_q <= 1'b0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					freq_q <= start_q;
					if (sw_en)
						st_q <= ST_WAIT;
				end
				ST_WAIT: begin
					// Edges that arrive mid-sweep are not counted
					if (!sw_en)
						st_q <= ST_IDLE;
					else if (start_ev) begin
						st_q       <= ST_DIV;
						dvd_q      <= mag;
						rem_q      <= 20'h0;
						bit_q      <= 6'h0;
						freq_q     <= start_q;
						step_idx_q <= 19'h0;
						step_cnt_q <= 32'h0;
						mark_lvl_q <= 1'b1;
					end
				end
				ST_DIV: begin
					// Serial divide span/steps; 48 cycles, far under a step
					dvd_q <= {dvd_q[46:0], 1'b0};
					if (rsh >= {1'b0, steps}) begin
						rem_q <= rsh - {1'b0, steps};
						quo_q <= {quo_q[46:0], 1'b1};
					end else begin
						rem_q <= rsh;
						quo_q <= {quo_q[46:0], 1'b0};
					end
					bit_q      <= bit_q + 6'h1;
					step_cnt_q <= step_cnt_q + 32'h1;
					if (bit_q == 6'h2F) begin
						inc_q <= {quo_q[46:0], rsh >= {1'b0, steps}};
						st_q  <= ST_RUN;
					end
				end
				ST_RUN: begin
					step_cnt_q <= tick ? 32'h0 : step_cnt_q + 32'h1;
					if ((up && freq_q >= mark_q) || (!up && freq_q <= mark_q))
						mark_lvl_q <= 1'b0;
					if (tick) begin
						step_idx_q <= step_idx_q + 19'h1;
						if (last) begin
							// Land exactly on stop; remainder lost on the way
							freq_q     <= stop_q;
							// Stop lies beyond the marker, so it is passed
							mark_lvl_q <= 1'b0;
							st_q       <= sw_en ? ST_WAIT : ST_IDLE;
						end else if (ctrl_q[`FSC_C_LOG])
							freq_q <= log_nx;
						else
							freq_q <= up ? freq_q + inc_q
								: freq_q - inc_q;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Trigger out, sync and lamp
	always @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			tp_cnt_q        <= 16'h0;
			O_TRIG_OUT      <= 1'b0;
			O_TRIG_OUT_OE_N <= 1'b1;
			O_SYNC          <= 1'b0;
			O_TRIG_LAMP     <= 1'b0;
			O_FREQ          <= `FSC_F_START_RST;
		end else begin
			if (st_q == ST_WAIT && start_ev && src == `FSC_SRC_BUS)
				tp_cnt_q <= TP_LAST;
			else if (tp_cnt_q != 16'h0)
				tp_cnt_q <= tp_cnt_q - 16'h1;
			// Shared connector is an input under the external source
			O_TRIG_OUT_OE_N <= ~(ctrl_q[`FSC_C_TOUT_EN] & sw_en &
				(src != `FSC_SRC_EXT));
			if (src == `FSC_SRC_IMM)
				O_TRIG_OUT <= ctrl_q[`FSC_C_TOUT_NEG] ^ sq_hi;
			else
				O_TRIG_OUT <= ctrl_q[`FSC_C_TOUT_NEG] ^
					(tp_cnt_q != 16'h0);
			if (ctrl_q[`FSC_C_MARK_EN] && sw_en)
				O_SYNC <= mark_lvl_q;
			else
				O_SYNC <= ctrl_q[`FSC_C_SYNC_EN] & I_CARRIER_SYNC;
			O_TRIG_LAMP <= sw_en && st_q == ST_WAIT &&
				src == `FSC_SRC_BUS;
			O_FREQ <= freq_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path: data only in the cycle after the strobe
	always @* begin
		case (I_ADDR)
			`FSC_A_CTRL:     rd_mux = {21'h0, ctrl_q};
			`FSC_A_STAT:     rd_mux = {24'h0, st_q, mark_lvl_q, 1'b0,
				conflict_q, opc_q};
			`FSC_A_TIME:     rd_mux = {13'h0, time_q};
			`FSC_A_START_LO: rd_mux = start_q[31:0];
			`FSC_A_START_HI: rd_mux = {16'h0, start_q[47:32]};
			`FSC_A_STOP_LO:  rd_mux = stop_q[31:0];
			`FSC_A_STOP_HI:  rd_mux = {16'h0, stop_q[47:32]};
			`FSC_A_CENT_LO:  rd_mux = center[31:0];
			`FSC_A_CENT_HI:  rd_mux = {16'h0, center[47:32]};
			`FSC_A_SPAN_LO:  rd_mux = span[31:0];
			`FSC_A_SPAN_HI:  rd_mux = {16'h0, span[47:32]};
			`FSC_A_MARK_LO:  rd_mux = mark_q[31:0];
			`FSC_A_MARK_HI:  rd_mux = {16'h0, mark_q[47:32]};
			`FSC_A_RATIO:    rd_mux = ratio_q;
			`FSC_A_FREQ_LO:  rd_mux = freq_q[31:0];
			`FSC_A_FREQ_HI:  rd_mux = {16'h0, freq_q[47:32]};
			default:         rd_mux = 32'h0000_0000;
		endcase
	end

	always @(posedge I_CORE_CLK) begin
		if (I_RST)
			O_RDATA <= 32'h0000_0000;
		else
			O_RDATA <= I_RD ? rd_mux : 32'h0000_0000;
	end

endmodule

// File: tb/fsc_trig_src.sv
`timescale 1ns/10ps
// External trigger source facing the shared trigger pin
module fsc_trig_src #(
	parameter GAP_NS = 1500
) (
	// Request from the bench
	input  wire i_go,
	input  wire i_neg,
	// Pin toward the block
	output wire o_pin
);
	time last_t = 0;
	reg  pulse  = 1'b0;
	// Idle level follows polarity, so each pulse leads with the chosen edge
	assign o_pin = i_neg ^ pulse;
	// Off-clock pulse, never closer than sweep time plus 1 ms
	always @(posedge i_go) begin
		while ($time < last_t + GAP_NS) #10;
		#3.3 pulse = 1'b1;
		last_t = $time;
		#50 pulse = 1'b0;
	end
endmodule

// File: tb/fsc_chk_sva.sv
`timescale 1ns/10ps
`include "fsc_defines.vh"
module fsc_chk (
	// Clock, reset and register port
	input wire        I_CORE_CLK,
	input wire        I_RST,
	input wire [7:0]  I_ADDR,
	input wire [31:0] I_WDATA,
	input wire        I_WR,
	// Pins
	input wire        I_CARRIER_SYNC,
	input wire        O_TRIG_OUT,
	input wire        O_TRIG_OUT_OE_N,
	input wire        O_SYNC,
	input wire        O_TRIG_LAMP,
	input wire        O_MODES_OFF,
	input wire [47:0] O_FREQ
);
	reg  [8:0] c_q;
	reg  [9:0] hi_q;
	wire [1:0] src = c_q[3:2];
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);
	////////////////////////////////////////
	// Shadow of control bits 8:0; combined_waveform_a also forces the immediate source
	always @(posedge I_CORE_CLK) begin
		if (I_RST)
			c_q <= 9'h000;
		else if (I_WR && I_ADDR == `FSC_A_CTRL)
			c_q <= I_WDATA[8:0];
		else if (I_WR && I_ADDR == `FSC_A_CMD && I_WDATA[`FSC_K_COMBINED_WAVEFORM_A])
			c_q[3:2] <= `FSC_SRC_IMM;
	end
	// Length of the running high phase, saturating to avoid wrap
	always @(posedge I_CORE_CLK) begin
		if (I_RST || !O_TRIG_OUT)
			hi_q <= 10'h000;
		else if (hi_q != 10'h3FF)
			hi_q <= hi_q + 10'h001;
	end
	////////////////////////////////////////
	a_modes_one: assert property (O_MODES_OFF |=> !O_MODES_OFF)
		else $error("modes-off pulse too long");
	a_modes_cause: assert property (O_MODES_OFF |-> c_q[0])
		else $error("modes-off without sweep enabled");
	a_modes_due: assert property ($rose(c_q[0]) |-> ##[0:2] O_MODES_OFF)
		else $error("modes-off missing after enable");
	a_ext_quiet: assert property ((src == `FSC_SRC_EXT)[*3]
		|-> O_TRIG_OUT_OE_N)
		else $error("trigger pin driven under external source");
	a_tout_off: assert property ((!c_q[5])[*3] |-> O_TRIG_OUT_OE_N)
		else $error("trigger pin driven while disabled");
	a_lamp_src: assert property ((src != `FSC_SRC_BUS)[*3]
		|-> !O_TRIG_LAMP)
		else $error("lamp lit outside bus source");
	a_bus_wide: assert property ($fell(O_TRIG_OUT) && src == `FSC_SRC_BUS
		&& c_q[5] && !c_q[6] |-> hi_q > 10'd200)
		else $error("bus trigger pulse too short");
	a_sync_car: assert property ((c_q[8] && !(c_q[7] && c_q[0]))[*3]
		|-> O_SYNC == $past(I_CARRIER_SYNC))
		else $error("sync does not follow carrier sync");
	a_sync_off: assert property ((!c_q[8] && !c_q[7])[*3] |-> !O_SYNC)
		else $error("sync active while disabled");
	a_freq_rng: assert property (O_FREQ != 48'h0
		&& O_FREQ <= `FSC_F_MAX)
		else $error("frequency out of range");
endmodule

bind fsc_sweep fsc_chk u_chk (
	.I_CORE_CLK     (I_CORE_CLK),
	.I_RST          (I_RST),
	.I_ADDR         (I_ADDR),
	.I_WDATA        (I_WDATA),
	.I_WR           (I_WR),
	.I_CARRIER_SYNC (I_CARRIER_SYNC),
	.O_TRIG_OUT     (O_TRIG_OUT),
	.O_TRIG_OUT_OE_N(O_TRIG_OUT_OE_N),
	.O_SYNC         (O_SYNC),
	.O_TRIG_LAMP    (O_TRIG_LAMP),
	.O_MODES_OFF    (O_MODES_OFF),
	.O_FREQ         (O_FREQ)
);

// File: tb/tb_top.sv
`timescale 1ns/10ps
`include "fsc_defines.vh"
module tb_top;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg  [7:0]  addr = 8'h00;
	reg  [31:0] wdata = 32'h0;
	reg         wr = 1'b0;
	reg         rd = 1'b0;
	reg         car = 1'b0;
	reg         go = 1'b0;
	reg         neg = 1'b0;
	wire        pin, tout, oe_n, sync, lamp, moff;
	wire [31:0] rdata;
	wire [47:0] freq;
	reg  [39:0] rows [0:8];
	integer     miscompares = 0;
	integer     cmp_count = 0;
	integer     i, k;
	// Short step keeps each simulated millisecond at 100 cycles
	fsc_sweep #(.STEP_CYC(100)) u_fsc_sweep (.I_CORE_CLK(clk),
		.I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
		.I_RD(rd), .O_RDATA(rdata), .I_TRIG_IN(pin),
		.I_CARRIER_SYNC(car), .O_TRIG_OUT(tout),
		.O_TRIG_OUT_OE_N(oe_n), .O_SYNC(sync), .O_TRIG_LAMP(lamp),
		.O_MODES_OFF(moff), .O_FREQ(freq));
	fsc_trig_src u_fsc_trig_src (.i_go(go), .i_neg(neg), .o_pin(pin));
	always #2.5 clk = ~clk;
	// Toggling carrier sync so the sync path is really exercised
	always @(posedge clk) car <= ~car;
	////////////////////////////////////////
	task chk(input [95:0] n, input [47:0] e, input [47:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				miscompares = miscompares + 1;
				$display("[FAIL] %0s exp %h got %h", n, e, g);
			end
		end
	endtask
	task bus_wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
		end
	endtask
	// Read data stand only in the cycle after the strobe
	task bus_rd(input [7:0] a, input [31:0] m, input [31:0] e);
		begin
			@(posedge clk);
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1;
			chk("rdata", {16'h0, e}, {16'h0, rdata & m});
		end
	endtask
	task wr48(input [7:0] a, input [47:0] v);
		begin
			bus_wr(a, v[31:0]);
			bus_wr(a + 8'h04, {16'h0, v[47:32]});
		end
	endtask
	task wait_f(input [47:0] v);
		begin
			k = 0;
			while (freq !== v && k < 3000) begin
				@(posedge clk);
				#1;
				k = k + 1;
			end
			chk("freq", v, freq);
		end
	endtask
	task final_report;
		begin
			$display("compares %0d mismatches %0d", cmp_count, miscompares);
			if (miscompares == 0 && cmp_count > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	////////////////////////////////////////
	// Watchdog: far beyond the few thousand cycles the tests need
	initial begin
		#150000;
		miscompares = miscompares + 1;
		final_report;
	end
	initial begin
		rows[0] = {`FSC_A_CTRL, 32'h0};
		rows[1] = {`FSC_A_TIME, 32'h3E8};
		rows[2] = {`FSC_A_START_LO, 32'h05F5E100};
		rows[3] = {`FSC_A_STOP_LO, 32'h3B9ACA00};
		rows[4] = {`FSC_A_CENT_LO, 32'h20C85580};
		rows[5] = {`FSC_A_SPAN_LO, 32'h35A4E900};
		rows[6] = {`FSC_A_MARK_LO, 32'h1DCD6500};
		rows[7] = {`FSC_A_RATIO, 32'h01000000};
		rows[8] = {8'hFC, 32'h0};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("freq", `FSC_F_START_RST, freq);
		chk("oe_n", 48'h1, {47'h0, oe_n});
		for (i = 0; i < 9; i = i + 1)
			bus_rd(rows[i][39:32], 32'hFFFFFFFF, rows[i][31:0]);
		// Ceilings for the default, ramp and arb functions
		wr48(`FSC_A_START_LO, 48'hFFFF_FFFF_FFFF);
		bus_rd(`FSC_A_START_LO, 32'hFFFFFFFF, 32'h73950000);
		bus_wr(`FSC_A_CTRL, 32'h400);
		wr48(`FSC_A_START_LO, 48'hFFFF_FFFF_FFFF);
		bus_rd(`FSC_A_START_LO, 32'hFFFFFFFF, 32'hD4A51000);
		bus_wr(`FSC_A_CTRL, 32'h600);
		wr48(`FSC_A_STOP_LO, 48'hFFFF_FFFF_FFFF);
		bus_rd(`FSC_A_STOP_LO, 32'hFFFFFFFF, 32'hC41E9000);
		// Downward pair: negative span, same midpoint
		bus_wr(`FSC_A_CTRL, 32'h0);
		wr48(`FSC_A_START_LO, `FSC_F_STOP_RST);
		wr48(`FSC_A_STOP_LO, `FSC_F_START_RST);
		bus_rd(`FSC_A_SPAN_LO, 32'hFFFFFFFF, 32'hCA5B1700);
		bus_rd(`FSC_A_CENT_LO, 32'hFFFFFFFF, 32'h20C85580);
		// External falling-edge sweep, 2 ms, marker on
		bus_wr(`FSC_A_TIME, 32'h2);
		bus_wr(`FSC_A_CMD, 32'h4);
		neg <= 1'b1;
		bus_wr(`FSC_A_CTRL, 32'hB5);
		// The pulse stands only in the cycle right after the write
		#1;
		chk("modes", 48'h1, {47'h0, moff});
		repeat (2) @(posedge clk);
		#1;
		chk("oe_n", 48'h1, {47'h0, oe_n});
		go <= 1'b1;
		wait_f(`FSC_F_STOP_RST);
		wait_f(48'h0000_20C8_5580);
		chk("sync", 48'h1, {47'h0, sync});
		wait_f(`FSC_F_START_RST);
		repeat (2) @(posedge clk);
		#1;
		chk("sync", 48'h0, {47'h0, sync});
		bus_rd(`FSC_A_STAT, 32'h1, 32'h1);
		repeat (100) @(posedge clk);
		#1;
		chk("freq", `FSC_F_START_RST, freq);
		go <= 1'b0;
		// Marker outside the range is pulled to the nearer end
		wr48(`FSC_A_MARK_LO, 48'h0000_7735_9400);
		bus_rd(`FSC_A_MARK_LO, 32'hFFFFFFFF, 32'h3B9ACA00);
		bus_rd(`FSC_A_STAT, 32'h2, 32'h2);
		// Bus-triggered log sweep upward, half ratio
		wr48(`FSC_A_START_LO, `FSC_F_START_RST);
		wr48(`FSC_A_STOP_LO, `FSC_F_STOP_RST);
		bus_wr(`FSC_A_RATIO, 32'h80000000);
		bus_wr(`FSC_A_CTRL, 32'h2B);
		repeat (3) @(posedge clk);
		#1;
		chk("lamp", 48'h1, {47'h0, lamp});
		chk("oe_n", 48'h0, {47'h0, oe_n});
		bus_wr(`FSC_A_CMD, 32'h1);
		repeat (3) @(posedge clk);
		#1;
		chk("tout", 48'h1, {47'h0, tout});
		chk("lamp", 48'h0, {47'h0, lamp});
		wait_f(48'h0000_08F0_D180);
		wait_f(`FSC_F_STOP_RST);
		for (k = 0; k < 600 && tout; k = k + 1) begin
			@(posedge clk);
			#1;
		end
		chk("tout", 48'h0, {47'h0, tout});
		// Immediate source: repeating sweeps with a square trigger out
		bus_wr(`FSC_A_CTRL, 32'h121);
		for (k = 0; k < 600 && !tout; k = k + 1) begin
			@(posedge clk);
			#1;
		end
		chk("oe_n", 48'h0, {47'h0, oe_n});
		for (i = 0; i < 600 && tout; i = i + 1) begin
			@(posedge clk);
			#1;
		end
		for (k = i; k < 600 && !tout; k = k + 1) begin
			@(posedge clk);
			#1;
		end
		// Half of a 2 ms sweep at 100 cycles per ms
		chk("high", 48'h64, {16'h0, i});
		// Sweep time plus the one restart cycle
		chk("period", 48'hC9, {16'h0, k});
		// Combined_waveform_a forces the immediate source
		bus_wr(`FSC_A_CTRL, 32'h9);
		bus_wr(`FSC_A_CMD, 32'h2);
		bus_rd(`FSC_A_CTRL, 32'hC, 32'h0);
		final_report;
	end
endmodule
